// >>> core/irq_clear_ref_ctrl.sv
/*
  Command register bank of the clock translator on an AXI4-Lite slave: interrupt clear pulses,
  phase offset step pulses, forced validation timeouts and reference monitor override and bypass.
  Assumes the interrupt monitor, phase accumulator, reference monitors and validation timers sit
  outside and act on one-cycle pulses and steady levels from this block.
*/
`timescale 1ns/100ps
`default_nettype none
module irq_clear_ref_ctrl import clear_ctrl_pkg::*; (
  input wire logic i_mclk,                     // System clock, 200 MHz
  input wire logic i_rst_n,                    // Async reset, active low
  // AXI4-Lite write address
  input wire logic [15:0] i_s_axi_awaddr,      // Write byte address
  input wire logic [2:0] i_s_axi_awprot,       // Protection, unused
  input wire logic i_s_axi_awvalid,            // Write address valid
  output logic o_s_axi_awready,                // Write address ready
  // AXI4-Lite write data
  input wire logic [31:0] i_s_axi_wdata,       // Write data
  input wire logic [3:0] i_s_axi_wstrb,        // Byte enables
  input wire logic i_s_axi_wvalid,             // Write data valid
  output logic o_s_axi_wready,                 // Write data ready
  // AXI4-Lite write response
  output logic [1:0] o_s_axi_bresp,            // Write response
  output logic o_s_axi_bvalid,                 // Write response valid
  input wire logic i_s_axi_bready,             // Write response ready
  // AXI4-Lite read address
  input wire logic [15:0] i_s_axi_araddr,      // Read byte address
  input wire logic [2:0] i_s_axi_arprot,       // Protection, unused
  input wire logic i_s_axi_arvalid,            // Read address valid
  output logic o_s_axi_arready,                // Read address ready
  // AXI4-Lite read data
  output logic [31:0] o_s_axi_rdata,           // Read data
  output logic [1:0] o_s_axi_rresp,            // Read response
  output logic o_s_axi_rvalid,                 // Read data valid
  input wire logic i_s_axi_rready,             // Read data ready
  // Interrupt monitor clears
  output logic [7:0] o_loop_event_clear,       // Digital loop event clears
  output logic [4:0] o_history_event_clear,    // History, clamp, slew clears
  output logic [2:0] o_first_ref_event_clear,  // First input clears
  output logic [2:0] o_second_ref_event_clear, // Second input clears
  // Phase offset accumulator commands
  output logic o_phase_offset_zero,            // Zero the offset
  output logic o_phase_offset_step_down,       // Subtract step once
  output logic o_phase_offset_step_up,         // Add step once
  // Validation timers and reference monitors
  output logic o_first_ref_force_valid,        // Expire first timer now
  output logic o_second_ref_force_valid,       // Expire second timer now
  output logic o_first_ref_invalid,            // First input forced invalid
  output logic o_second_ref_invalid,           // Second input forced invalid
  output logic o_first_ref_bypass,             // First monitor bypassed
  output logic o_second_ref_bypass             // Second monitor bypassed
);

  // ==========================================================================
  // Write channel holding state
  logic aw_held;
  logic w_held;
  logic [13:0] aw_index;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic wr_mapped;

  // ==========================================================================
  // Read channel holding state
  logic ar_held;
  logic [13:0] ar_index;
  logic next_ar_held;
  logic do_read;

  // ==========================================================================
  // Steady control registers
  logic [7:0] override_reg;
  logic [7:0] bypass_reg;

  // ==========================================================================
  // Strobe register carriers
  byte_write_if loop_wp ();
  byte_write_if hist_wp ();
  byte_write_if ref_wp ();
  byte_write_if phase_wp ();
  byte_write_if force_wp ();

  logic [7:0] loop_pulse;
  logic [4:0] hist_pulse;
  logic [7:0] ref_pulse;
  logic [2:0] phase_pulse;
  logic [1:0] force_pulse;

  // ==========================================================================
  // Write handshake: address and data are taken in either order and held
  // until both are present and no response is still waiting
  assign do_write = aw_held && w_held && !o_s_axi_bvalid;
  assign next_aw_held = (aw_held || (i_s_axi_awvalid && o_s_axi_awready)) && !do_write;
  assign next_w_held = (w_held || (i_s_axi_wvalid && o_s_axi_wready)) && !do_write;

  // Held flags
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
    end
  end

  // Ready flags come from flops; one slot each, so ready drops while held
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
    end else begin
      o_s_axi_awready <= !next_aw_held;
      o_s_axi_wready <= !next_w_held;
    end
  end

  // Capture address index and the low byte lane
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_index <= '0;
      w_byte <= RST_BYTE;
      w_lane0 <= 1'b0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_index <= i_s_axi_awaddr[15:2];
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_byte <= i_s_axi_wdata[7:0];
        w_lane0 <= i_s_axi_wstrb[0];
      end
    end
  end

  // Write address decode; the spare byte is mapped but inert
  always_comb begin
    if (aw_index == IDX_LOOP_CLR) begin
      wr_mapped = 1'b1;
    end else if (aw_index == IDX_HIST_CLR) begin
      wr_mapped = 1'b1;
    end else if (aw_index == IDX_REF_CLR) begin
      wr_mapped = 1'b1;
    end else if (aw_index == IDX_SPARE) begin
      wr_mapped = 1'b1;
    end else if (aw_index == IDX_PHASE_CTRL) begin
      wr_mapped = 1'b1;
    end else if (aw_index == IDX_TIMER_FORCE) begin
      wr_mapped = 1'b1;
    end else if (aw_index == IDX_OVERRIDE) begin
      wr_mapped = 1'b1;
    end else if (aw_index == IDX_BYPASS) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (o_s_axi_bvalid && i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Strobe decode: only byte lane 0 carries register data
  assign loop_wp.wr_en = do_write && w_lane0 && (aw_index == IDX_LOOP_CLR);
  assign loop_wp.wdata = w_byte;
  assign hist_wp.wr_en = do_write && w_lane0 && (aw_index == IDX_HIST_CLR);
  assign hist_wp.wdata = w_byte;
  assign ref_wp.wr_en = do_write && w_lane0 && (aw_index == IDX_REF_CLR);
  assign ref_wp.wdata = w_byte;
  assign phase_wp.wr_en = do_write && w_lane0 && (aw_index == IDX_PHASE_CTRL);
  assign phase_wp.wdata = w_byte;
  assign force_wp.wr_en = do_write && w_lane0 && (aw_index == IDX_TIMER_FORCE);
  assign force_wp.wdata = w_byte;

  // ==========================================================================
  // Self-clearing command registers
  autoclear_strobe #(.WIDTH(8), .MASK(MASK_LOOP_CLR)) u_loop_clr (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .wp(loop_wp.sink),
    .o_pulse(loop_pulse)
  );

  autoclear_strobe #(.WIDTH(5), .MASK(MASK_HIST_CLR)) u_hist_clr (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .wp(hist_wp.sink),
    .o_pulse(hist_pulse)
  );

  autoclear_strobe #(.WIDTH(8), .MASK(MASK_REF_CLR)) u_ref_clr (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .wp(ref_wp.sink),
    .o_pulse(ref_pulse)
  );

  autoclear_strobe #(.WIDTH(3), .MASK(MASK_PHASE_CTRL)) u_phase_ctrl (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .wp(phase_wp.sink),
    .o_pulse(phase_pulse)
  );

  autoclear_strobe #(.WIDTH(2), .MASK(MASK_TIMER_FORCE)) u_timer_force (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .wp(force_wp.sink),
    .o_pulse(force_pulse)
  );

  // ==========================================================================
  // Pulse fan-out; each output is a slice of a strobe flop
  assign o_loop_event_clear = loop_pulse;
  assign o_history_event_clear = hist_pulse;
  assign o_second_ref_event_clear = ref_pulse[REF_SECOND_LO +: 3];
  assign o_first_ref_event_clear = ref_pulse[REF_FIRST_LO +: 3];
  assign o_phase_offset_zero = phase_pulse[PH_ZERO_BIT];
  assign o_phase_offset_step_down = phase_pulse[PH_DOWN_BIT];
  assign o_phase_offset_step_up = phase_pulse[PH_UP_BIT];
  // Force pulses are passed as written; a write that sets bypass in the same
  // cycle is not blocked here, so ordering stays software's duty
  assign o_second_ref_force_valid = force_pulse[SECOND_REF_BIT];
  assign o_first_ref_force_valid = force_pulse[FIRST_REF_BIT];

  // ==========================================================================
  // Override register: steady level, reset clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      override_reg <= RST_BYTE;
    end else if (do_write && w_lane0 && (aw_index == IDX_OVERRIDE)) begin
      override_reg <= w_byte & MASK_REF_SEL;
    end
  end

  // Bypass register: steady level, reset clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bypass_reg <= RST_BYTE;
    end else if (do_write && w_lane0 && (aw_index == IDX_BYPASS)) begin
      bypass_reg <= w_byte & MASK_REF_SEL;
    end
  end

  assign o_second_ref_invalid = override_reg[SECOND_REF_BIT];
  assign o_first_ref_invalid = override_reg[FIRST_REF_BIT];
  assign o_second_ref_bypass = bypass_reg[SECOND_REF_BIT];
  assign o_first_ref_bypass = bypass_reg[FIRST_REF_BIT];

  // ==========================================================================
  // Read handshake: one read held at a time, answered the cycle after
  assign do_read = ar_held && !o_s_axi_rvalid;
  assign next_ar_held = (ar_held || (i_s_axi_arvalid && o_s_axi_arready)) && !do_read;

  // Read held flag, ready and address
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ar_held <= 1'b0;
      o_s_axi_arready <= 1'b0;
      ar_index <= '0;
    end else begin
      ar_held <= next_ar_held;
      o_s_axi_arready <= !next_ar_held;
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        ar_index <= i_s_axi_araddr[15:2];
      end
    end
  end

  // Read data; command registers and the spare byte return a constant zero, not their pulse bits
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= '0;
      o_s_axi_rresp <= RESP_OKAY;
    end else if (do_read) begin
      o_s_axi_rvalid <= 1'b1;
      if (ar_index == IDX_OVERRIDE) begin
        o_s_axi_rdata <= {24'h000000, override_reg};
        o_s_axi_rresp <= RESP_OKAY;
      end else if (ar_index == IDX_BYPASS) begin
        o_s_axi_rdata <= {24'h000000, bypass_reg};
        o_s_axi_rresp <= RESP_OKAY;
      end else if ((ar_index >= IDX_LOOP_CLR) && (ar_index <= IDX_TIMER_FORCE)) begin
        o_s_axi_rdata <= '0;
        o_s_axi_rresp <= RESP_OKAY;
      end else begin
        o_s_axi_rdata <= '0;
        o_s_axi_rresp <= RESP_SLVERR;
      end
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> include/clear_ctrl_pkg.sv
/*
  Constants for the command register bank: register indices, bit positions, masks, reset values and bus codes.
  Assumes an AXI4-Lite master with 32-bit data and a 16-bit byte address.
*/
package clear_ctrl_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [13:0] IDX_LOOP_CLR = 14'h0a06;
  localparam logic [13:0] IDX_HIST_CLR = 14'h0a07;
  localparam logic [13:0] IDX_REF_CLR = 14'h0a08;
  localparam logic [13:0] IDX_SPARE = 14'h0a09;
  localparam logic [13:0] IDX_PHASE_CTRL = 14'h0a0a;
  localparam logic [13:0] IDX_TIMER_FORCE = 14'h0a0b;
  localparam logic [13:0] IDX_OVERRIDE = 14'h0a0c;
  localparam logic [13:0] IDX_BYPASS = 14'h0a0d;

  // ==========================================================================
  // Writable bit masks; everything outside reads zero and ignores writes
  localparam logic [7:0] MASK_LOOP_CLR = 8'hff;
  localparam logic [7:0] MASK_HIST_CLR = 8'h1f;
  localparam logic [7:0] MASK_REF_CLR = 8'h77;
  localparam logic [7:0] MASK_PHASE_CTRL = 8'h07;
  localparam logic [7:0] MASK_TIMER_FORCE = 8'h03;
  localparam logic [7:0] MASK_REF_SEL = 8'h03;

  // ==========================================================================
  // Bit positions
  localparam int REF_SECOND_LO = 4;
  localparam int REF_FIRST_LO = 0;
  localparam int PH_ZERO_BIT = 2;
  localparam int PH_DOWN_BIT = 1;
  localparam int PH_UP_BIT = 0;
  localparam int SECOND_REF_BIT = 1;
  localparam int FIRST_REF_BIT = 0;

  // ==========================================================================
  // Reset values and bus answers
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> include/byte_write_if.sv
/*
  Carrier for one register's write strobe and data byte between the bus slave and a strobe register.
  Assumes a single clock domain; the strobe is one cycle long.
*/
`timescale 1ns/100ps
`default_nettype none
interface byte_write_if;
  logic wr_en;
  logic [7:0] wdata;
  modport source (output wr_en, output wdata);
  modport sink (input wr_en, input wdata);
endinterface
`default_nettype wire

// >>> core/autoclear_strobe.sv
/*
  One self-clearing command register: a written one appears as a single-cycle pulse, then drops.
  Assumes the write strobe is already decoded and byte-enabled by the bus slave.
*/
`timescale 1ns/100ps
`default_nettype none
module autoclear_strobe #(
  parameter int WIDTH = 8,
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic i_mclk,            // System clock
  input wire logic i_rst_n,           // Async reset, active low
  byte_write_if.sink wp,              // Decoded write strobe and byte
  output logic [WIDTH-1:0] o_pulse    // One-cycle command pulses
);

  // ==========================================================================
  // Pulse register: loads masked data on a write, zero on every other cycle
  // so a command can never stay asserted
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pulse <= '0;
    end else if (wp.wr_en) begin
      o_pulse <= WIDTH'(wp.wdata & MASK);
    end else begin
      o_pulse <= '0;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/irq_clear_ref_ctrl_properties.sv
/*
  Concurrent checks on the command register bank ports: pulse values, pulse timing, level registers.
  Assumes it is bound into irq_clear_ref_ctrl and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module irq_clear_ref_ctrl_properties import clear_ctrl_pkg::*; (
  input wire logic i_mclk,                     // Clock
  input wire logic i_rst_n,                    // Reset, active low
  input wire logic [15:0] i_s_axi_awaddr,      // Write address
  input wire logic i_s_axi_awvalid,            // Address valid
  input wire logic o_s_axi_awready,            // Address ready
  input wire logic [31:0] i_s_axi_wdata,       // Write data
  input wire logic [3:0] i_s_axi_wstrb,        // Byte enables
  input wire logic i_s_axi_wvalid,             // Data valid
  input wire logic o_s_axi_wready,             // Data ready
  input wire logic o_s_axi_bvalid,             // Response valid
  input wire logic [31:0] o_s_axi_rdata,       // Read data
  input wire logic o_s_axi_rvalid,             // Read valid
  input wire logic [7:0] o_loop_event_clear,   // Loop clears
  input wire logic [4:0] o_history_event_clear, // History clears
  input wire logic [2:0] o_first_ref_event_clear, // First input clears
  input wire logic [2:0] o_second_ref_event_clear, // Second input clears
  input wire logic o_phase_offset_zero,        // Zero offset
  input wire logic o_phase_offset_step_down,   // Step down
  input wire logic o_phase_offset_step_up,     // Step up
  input wire logic o_first_ref_force_valid,    // First forced valid
  input wire logic o_second_ref_force_valid,   // Second forced valid
  input wire logic o_first_ref_invalid,        // First forced invalid
  input wire logic o_second_ref_invalid,       // Second forced invalid
  input wire logic o_first_ref_bypass,         // First bypassed
  input wire logic o_second_ref_bypass         // Second bypassed
);
  // ==========================================================================
  // Capture of the write in flight
  logic [13:0] cap_idx;
  logic [7:0] cap_data;
  logic cap_strb;
  wire logic [23:0] pulse_vec = {o_loop_event_clear, o_history_event_clear, o_second_ref_event_clear,
    o_first_ref_event_clear, o_phase_offset_zero, o_phase_offset_step_down, o_phase_offset_step_up,
    o_second_ref_force_valid, o_first_ref_force_valid};
  wire logic [3:0] level_vec = {o_second_ref_bypass, o_first_ref_bypass, o_second_ref_invalid, o_first_ref_invalid};

  // Safe to keep only the last capture: the next write is taken only after this one executes
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap_idx <= '0;
      cap_data <= 8'h00;
      cap_strb <= 1'b0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) cap_idx <= i_s_axi_awaddr[15:2];
      if (i_s_axi_wvalid && o_s_axi_wready) cap_data <= i_s_axi_wdata[7:0];
      if (i_s_axi_wvalid && o_s_axi_wready) cap_strb <= i_s_axi_wstrb[0];
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_loop_clear_value: assert property ($rose(o_s_axi_bvalid) && cap_strb && cap_idx == IDX_LOOP_CLR
    |-> o_loop_event_clear == cap_data) else $error("loop clear pulses differ from written byte");
  a_hist_clear_value: assert property ($rose(o_s_axi_bvalid) && cap_strb && cap_idx == IDX_HIST_CLR
    |-> o_history_event_clear == cap_data[4:0]) else $error("history clear pulses differ from written byte");
  a_ref_clear_value: assert property ($rose(o_s_axi_bvalid) && cap_strb && cap_idx == IDX_REF_CLR
    |-> {o_second_ref_event_clear, o_first_ref_event_clear} == {cap_data[6:4], cap_data[2:0]})
    else $error("reference clear pulses differ from written byte");
  a_phase_cmd_value: assert property ($rose(o_s_axi_bvalid) && cap_strb && cap_idx == IDX_PHASE_CTRL
    |-> {o_phase_offset_zero, o_phase_offset_step_down, o_phase_offset_step_up} == cap_data[2:0])
    else $error("phase command pulses differ from written byte");
  a_force_pulse_value: assert property ($rose(o_s_axi_bvalid) && cap_strb && cap_idx == IDX_TIMER_FORCE
    |-> {o_second_ref_force_valid, o_first_ref_force_valid} == cap_data[1:0])
    else $error("forced timeout pulses differ from written byte");
  a_override_level: assert property ($rose(o_s_axi_bvalid) && cap_strb && cap_idx == IDX_OVERRIDE
    |=> {o_second_ref_invalid, o_first_ref_invalid} == $past(cap_data[1:0]))
    else $error("override levels differ from written byte");
  a_bypass_level: assert property ($rose(o_s_axi_bvalid) && cap_strb && cap_idx == IDX_BYPASS
    |=> {o_second_ref_bypass, o_first_ref_bypass} == $past(cap_data[1:0]))
    else $error("bypass levels differ from written byte");
  a_pulse_self_clear: assert property ((|pulse_vec) |-> $rose(o_s_axi_bvalid) ##1 pulse_vec == 24'h000000)
    else $error("command pulse not single cycle at write execution");
  a_level_only_write: assert property (!$stable(level_vec) |-> $past(o_s_axi_bvalid) || o_s_axi_bvalid)
    else $error("level register changed without a write");
  a_read_upper_zero: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
endmodule

bind irq_clear_ref_ctrl irq_clear_ref_ctrl_properties i_props (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
  .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wstrb(i_s_axi_wstrb),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rvalid(o_s_axi_rvalid), .o_loop_event_clear(o_loop_event_clear),
  .o_history_event_clear(o_history_event_clear), .o_first_ref_event_clear(o_first_ref_event_clear),
  .o_second_ref_event_clear(o_second_ref_event_clear), .o_phase_offset_zero(o_phase_offset_zero),
  .o_phase_offset_step_down(o_phase_offset_step_down), .o_phase_offset_step_up(o_phase_offset_step_up),
  .o_first_ref_force_valid(o_first_ref_force_valid), .o_second_ref_force_valid(o_second_ref_force_valid),
  .o_first_ref_invalid(o_first_ref_invalid), .o_second_ref_invalid(o_second_ref_invalid),
  .o_first_ref_bypass(o_first_ref_bypass), .o_second_ref_bypass(o_second_ref_bypass));
`default_nettype wire

// >>> testbench/irq_clear_ref_ctrl_tb.sv
/*
  Self-checking bench for the command register bank, driven as an AXI4-Lite master.
  Assumes the package constants and a single 200 MHz clock; pulses are sampled on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module irq_clear_ref_ctrl_tb import clear_ctrl_pkg::*;;
  logic i_mclk = 1'b0, i_rst_n = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] loop_clr;
  logic [4:0] hist_clr;
  logic [2:0] first_clr, second_clr;
  logic zero_p, down_p, up_p, first_force, second_force, first_inv, second_inv, first_byp, second_byp;
  logic [23:0] seen_pulse;
  int pulse_cycles, bad_count = 0, n_tests = 0;
  wire logic [3:0] level_vec = {second_byp, first_byp, second_inv, first_inv};

  // ==========================================================================
  // Clock, design, pulse monitor
  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end

  irq_clear_ref_ctrl i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_loop_event_clear(loop_clr), .o_history_event_clear(hist_clr),
    .o_first_ref_event_clear(first_clr), .o_second_ref_event_clear(second_clr), .o_phase_offset_zero(zero_p),
    .o_phase_offset_step_down(down_p), .o_phase_offset_step_up(up_p), .o_first_ref_force_valid(first_force),
    .o_second_ref_force_valid(second_force), .o_first_ref_invalid(first_inv), .o_second_ref_invalid(second_inv),
    .o_first_ref_bypass(first_byp), .o_second_ref_bypass(second_byp));

  // Falling-edge sampling keeps the one-cycle pulses clear of the launching edge
  always @(negedge i_mclk) begin
    if (|{loop_clr, hist_clr, second_clr, first_clr, zero_p, down_p, up_p, second_force, first_force}) begin
      seen_pulse = seen_pulse | {loop_clr, hist_clr, second_clr, first_clr, zero_p, down_p, up_p, second_force,
        first_force};
      pulse_cycles++;
    end
  end

  // ==========================================================================
  // Checking and bus tasks
  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask

  function automatic logic [23:0] exp_pulse(input logic [13:0] idx, input logic [7:0] d);
    case (idx)
      IDX_LOOP_CLR: exp_pulse = {d, 16'h0000};
      IDX_HIST_CLR: exp_pulse = {8'h00, d[4:0], 11'h000};
      IDX_REF_CLR: exp_pulse = {13'h0000, d[6:4], d[2:0], 5'h00};
      IDX_PHASE_CTRL: exp_pulse = {19'h00000, d[2:0], 2'h0};
      IDX_TIMER_FORCE: exp_pulse = {22'h000000, d[1:0]};
      default: exp_pulse = 24'h000000;
    endcase
  endfunction

  // Address and data are offered together; each valid drops at its own handshake
  task automatic wr_chk(input logic [13:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic got;
    logic [23:0] exp;
    got = 1'b0;
    exp = (s[0] && er === RESP_OKAY) ? exp_pulse(idx, d[7:0]) : 24'h000000;
    seen_pulse = 24'h000000;
    pulse_cycles = 0;
    @(posedge i_mclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge i_mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        check("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
      end
    end
    check("pulses", {8'h00, seen_pulse}, {8'h00, exp});
    check("pulse cycles", pulse_cycles, (exp != 24'h000000) ? 1 : 0);
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge i_mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge i_mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        check("rdata", rdata, exp);
        check("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
      end
    end
  endtask

  // ==========================================================================
  // Test sequence and watchdog
  logic [13:0] cmd_idx [6] = '{IDX_LOOP_CLR, IDX_HIST_CLR, IDX_REF_CLR, IDX_SPARE, IDX_PHASE_CTRL, IDX_TIMER_FORCE};
  logic [31:0] vals [3] = '{32'hffffffff, 32'h000000a5, 32'h0000005a};

  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    check("reset levels", {28'h0, level_vec}, 32'h0);
    rd_chk(IDX_OVERRIDE, 32'h0, RESP_OKAY);
    rd_chk(IDX_BYPASS, 32'h0, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        wr_chk(cmd_idx[i], vals[j], 4'hf, RESP_OKAY);
        rd_chk(cmd_idx[i], 32'h0, RESP_OKAY);
      end
    end
    wr_chk(IDX_LOOP_CLR, 32'hff, 4'he, RESP_OKAY);
    wr_chk(IDX_OVERRIDE, 32'hffffffff, 4'hf, RESP_OKAY);
    rd_chk(IDX_OVERRIDE, 32'h3, RESP_OKAY);
    check("levels", {28'h0, level_vec}, 32'h3);
    wr_chk(IDX_OVERRIDE, 32'h2, 4'h1, RESP_OKAY);
    wr_chk(IDX_BYPASS, 32'h1, 4'h1, RESP_OKAY);
    rd_chk(IDX_BYPASS, 32'h1, RESP_OKAY);
    check("levels", {28'h0, level_vec}, 32'h6);
    wr_chk(IDX_TIMER_FORCE, 32'h1, 4'h1, RESP_OKAY);
    wr_chk(IDX_BYPASS, 32'hfe, 4'h1, RESP_OKAY);
    check("levels", {28'h0, level_vec}, 32'ha);
    wr_chk(14'h0a0e, 32'hff, 4'hf, RESP_SLVERR);
    rd_chk(14'h0a0e, 32'h0, RESP_SLVERR);
    check("levels", {28'h0, level_vec}, 32'ha);
    // Second reset in mid-run returns the level registers to their defaults
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    check("levels", {28'h0, level_vec}, 32'h0);
    rd_chk(IDX_BYPASS, 32'h0, RESP_OKAY);
    finish_test();
  end

  // The whole sequence takes well under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
